// file: core/dsp_flag_and_mailbox_io.sv
`timescale 1ns/1ps

// How it works
// R01 - Shared pads 6..11 carry OR of audio and rate-converter flag outputs.
// R02 - Shared pad is input only when both cores set that flag as input.
// R03 - Every user flag has programmable direction and stretch bits.
// R04 - Audio flags 4 and 5 drive their own dedicated pads.
// R05 - Pad eleven carries watchdog flag when the watchdog control bit says.
// R06 - Flag 12 goes to watchdog status, still with direction and stretch.
// R07 - Audio input mux select and output latch enables decode from instruction.
// R08 - Two mailbox channels, one per direction, each two 24-bit words.
// R09 - Audio writes forward channel; radio writes reverse channel.
// R10 - Mailbox data readable regardless of handshake flag state.
// R11 - Handshake flags change only on second-word write or read.
// R12 - Sender write and receiver read make buffer-empty and buffer-full.
// R13 - Cores wait one instruction after second-word write before testing.
// R14 - Six new-sample flags: input, stretched, only enable bit programmable.
// R15 - Flag 0 is reference rate; flags 1..5 are sources 1..5.
// R16 - Timestamp inputs for five sources plus one reference.
// R17 - Each input picks one of eight sources and a data format.
// R18 - Select and format bits writable by audio core and host port.
// R19 - Second-word write sets full, clears empty; read does the reverse.
// R20 - Stretched input holds a pulse until sampled; else follows pin.
// R21 - Disabled new-sample flag reads low and ignores indications.
module dsp_flag_and_mailbox_io #(
	parameter int NUM_SEL = 8,
	parameter int NUM_LE  = 8
) (
	// Clock and reset.
	input  wire logic                                      i_mclk,
	input  wire logic                                      i_rstn,
	// Configuration from host port and audio core.
	input  wire flag_mbox_pkg::cfg_req_s                   i_host_cfg,
	input  wire flag_mbox_pkg::cfg_req_s                   i_aud_cfg,
	output logic [7:0]                                     o_cfg_rdata,
	// Core flag outputs (flags 4..12 at index 0..8) and sample acknowledges.
	input  wire logic [flag_mbox_pkg::NUM_USER-1:0]        i_aud_flag_out,
	input  wire logic [flag_mbox_pkg::NUM_USER-1:0]        i_rc_flag_out,
	input  wire logic [flag_mbox_pkg::NUM_USER-1:0]        i_aud_sampled,
	input  wire logic [flag_mbox_pkg::NUM_USER-1:0]        i_rc_sampled,
	output logic [flag_mbox_pkg::NUM_USER-1:0]             o_aud_flag_in,
	output logic [flag_mbox_pkg::NUM_USER-1:0]             o_rc_flag_in,
	// Watchdog.
	input  wire logic                                      i_watchdog_flag_out,
	output logic [1:0]                                     o_wd_status_flag,
	// Shared pads 6..11 and dedicated pads 4, 5.
	input  wire logic [flag_mbox_pkg::NUM_SHARED-1:0]      i_shared_flag_pad,
	output logic [flag_mbox_pkg::NUM_SHARED-1:0]           o_shared_flag_pad,
	output logic [flag_mbox_pkg::NUM_SHARED-1:0]           o_shared_flag_pad_oe,
	input  wire logic [1:0]                                i_audio_flag_pad,
	output logic [1:0]                                     o_audio_flag_pad,
	output logic [1:0]                                     o_audio_flag_pad_oe,
	// New-sample indications, 0 reference, 1..5 sources.
	input  wire logic [flag_mbox_pkg::NUM_NEWSAM-1:0]      i_newsam,
	input  wire logic [flag_mbox_pkg::NUM_NEWSAM-1:0]      i_newsam_sampled,
	output logic [flag_mbox_pkg::NUM_NEWSAM-1:0]           o_newsam_flag,
	// Timestamps, entry 0 reference, 1..5 sources.
	input  wire logic [flag_mbox_pkg::NUM_NEWSAM*flag_mbox_pkg::WORD_W-1:0]
	                                                       i_tstamp,
	output logic [flag_mbox_pkg::NUM_NEWSAM*flag_mbox_pkg::WORD_W-1:0]
	                                                       o_tstamp,
	// Input switchbox and format settings.
	output logic [flag_mbox_pkg::NUM_INPUTS*flag_mbox_pkg::SEL_W-1:0]
	                                                       o_src_sel,
	output logic [flag_mbox_pkg::NUM_INPUTS*flag_mbox_pkg::FMT_W-1:0]
	                                                       o_src_fmt,
	// Audio core input mux and output latches.
	input  wire logic [$clog2(NUM_SEL)-1:0]                i_instr_sel,
	input  wire logic                                      i_instr_rd,
	input  wire logic [$clog2(NUM_LE)-1:0]                 i_instr_le,
	input  wire logic                                      i_instr_wr,
	input  wire logic [NUM_SEL*flag_mbox_pkg::WORD_W-1:0]  i_mux_src,
	output logic [flag_mbox_pkg::WORD_W-1:0]               o_ext_bus,
	output logic [NUM_LE-1:0]                              o_latch_en,
	// Mailbox ports.
	input  wire flag_mbox_pkg::mbox_req_s                  i_aud_mbox,
	input  wire flag_mbox_pkg::mbox_req_s                  i_rad_mbox,
	output logic [2*flag_mbox_pkg::WORD_W-1:0]             o_fwd_words,
	output logic [2*flag_mbox_pkg::WORD_W-1:0]             o_rev_words,
	output logic                                           o_aud_empty,
	output logic                                           o_rad_full,
	output logic                                           o_rad_empty,
	output logic                                           o_aud_full
);

	localparam int NU = flag_mbox_pkg::NUM_USER;
	localparam int NS = flag_mbox_pkg::NUM_SHARED;
	localparam int W  = flag_mbox_pkg::WORD_W;

	// Refuse counts the decode cannot serve; a single latch has no index.
	if (NUM_SEL < 2 || NUM_LE < 2) begin : g_bad_count
		$error("mux or latch count out of range");
	end

	// Configuration registers.
	logic [7:0]    wdt_ctl_q, wdt_ctl_d;
	logic [NU-1:0] aud_dir_q, aud_dir_d, rc_dir_q, rc_dir_d;
	logic [NU-1:0] aud_str_q, aud_str_d, rc_str_q, rc_str_d;
	logic [5:0]    ns_en_q, ns_en_d;
	logic [14:0]   sel_q, sel_d;
	logic [9:0]    fmt_q, fmt_d;
	logic [7:0]    rdata_d;
	flag_mbox_pkg::cfg_req_s req;

	// Synchronisers for pads and new-sample indications.
	logic [NS+1:0] pad_s1_q, pad_s2_q;
	logic [5:0]    ns_s1_q, ns_s2_q;
	logic [NU-1:0] pad_lvl;

	// Host port has priority when both write in the same cycle.
	always_comb begin
		req       = i_host_cfg.wr ? i_host_cfg : i_aud_cfg; // [R18]
		wdt_ctl_d = wdt_ctl_q;
		aud_dir_d = aud_dir_q;
		aud_str_d = aud_str_q;
		rc_dir_d  = rc_dir_q;
		rc_str_d  = rc_str_q;
		ns_en_d   = ns_en_q;
		sel_d     = sel_q;
		fmt_d     = fmt_q;
		if (req.wr) begin
			case (req.addr)
				flag_mbox_pkg::WDT_CTL_ADDR: wdt_ctl_d = req.wdata; // [R05]
				flag_mbox_pkg::AUD_DIR_ADDR: aud_dir_d = {aud_dir_q[8], req.wdata}; // [R03]
				flag_mbox_pkg::AUD_STR_ADDR: aud_str_d = {aud_str_q[8], req.wdata}; // [R03]
				flag_mbox_pkg::RC_DIR_ADDR:  rc_dir_d  = {rc_dir_q[8], req.wdata}; // [R03]
				flag_mbox_pkg::RC_STR_ADDR:  rc_str_d  = {rc_str_q[8], req.wdata}; // [R03]
				flag_mbox_pkg::NS_EN_ADDR: begin
					ns_en_d = req.wdata[5:0]; // [R14]
					// Bits 7:6 carry the flag 12 directions of both cores.
					aud_dir_d[8] = req.wdata[6]; // [R06]
					rc_dir_d[8]  = req.wdata[7]; // [R06]
				end
				flag_mbox_pkg::SRC_SEL_ADDR: sel_d = {sel_q[6:0], req.wdata}; // [R17]
				flag_mbox_pkg::FMT_ADDR: begin
					fmt_d = {fmt_q[1:0], req.wdata}; // [R17]
				end
				flag_mbox_pkg::FLAG_IN_ADDR: begin
					// Flag 12 stretch bits live here.
					aud_str_d[8] = req.wdata[0]; // [R06]
					rc_str_d[8]  = req.wdata[1]; // [R06]
				end
				default: ;
			endcase
		end
		rdata_d = 8'h00;
		case (i_host_cfg.addr)
			flag_mbox_pkg::WDT_CTL_ADDR: rdata_d = wdt_ctl_q;
			flag_mbox_pkg::AUD_DIR_ADDR: rdata_d = aud_dir_q[7:0];
			flag_mbox_pkg::AUD_STR_ADDR: rdata_d = aud_str_q[7:0];
			flag_mbox_pkg::RC_DIR_ADDR:  rdata_d = rc_dir_q[7:0];
			flag_mbox_pkg::RC_STR_ADDR:  rdata_d = rc_str_q[7:0];
			flag_mbox_pkg::NS_EN_ADDR:
				rdata_d = {rc_dir_q[8], aud_dir_q[8], ns_en_q};
			flag_mbox_pkg::SRC_SEL_ADDR: rdata_d = sel_q[7:0];
			flag_mbox_pkg::FMT_ADDR:     rdata_d = fmt_q[7:0];
			flag_mbox_pkg::FLAG_IN_ADDR: rdata_d = {2'b00, o_newsam_flag};
			default: rdata_d = 8'h00;
		endcase
	end

	// Register configuration state and the pad synchronisers.
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			wdt_ctl_q   <= flag_mbox_pkg::WDT_CTL_RESET;
			aud_dir_q   <= '0;
			aud_str_q   <= '0;
			rc_dir_q    <= '0;
			rc_str_q    <= '0;
			ns_en_q     <= '0;
			sel_q       <= '0;
			fmt_q       <= '0;
			o_cfg_rdata <= 8'h00;
			pad_s1_q    <= '0;
			pad_s2_q    <= '0;
			ns_s1_q     <= '0;
			ns_s2_q     <= '0;
		end else begin
			wdt_ctl_q   <= wdt_ctl_d;
			aud_dir_q   <= aud_dir_d;
			aud_str_q   <= aud_str_d;
			rc_dir_q    <= rc_dir_d;
			rc_str_q    <= rc_str_d;
			ns_en_q     <= ns_en_d;
			sel_q       <= sel_d;
			fmt_q       <= fmt_d;
			o_cfg_rdata <= rdata_d;
			pad_s1_q    <= {i_shared_flag_pad, i_audio_flag_pad};
			pad_s2_q    <= pad_s1_q;
			ns_s1_q     <= i_newsam;
			ns_s2_q     <= ns_s1_q;
		end
	end

	// Flag 12 has no pad; it reads back what the cores drive.
	assign pad_lvl = {i_aud_flag_out[8] | i_rc_flag_out[8], pad_s2_q}; // [R06]

	// Pad drive: dir bit set means output.
	logic [NS-1:0] sh_d, sh_oe_d;
	logic          wd_sel;
	assign wd_sel = wdt_ctl_q[flag_mbox_pkg::WD_SEL_BIT];
	always_comb begin
		for (int i = 0; i < NS; i++) begin
			sh_oe_d[i] = aud_dir_q[i+2] | rc_dir_q[i+2]; // [R02]
			sh_d[i]    = (aud_dir_q[i+2] & i_aud_flag_out[i+2])
			           | (rc_dir_q[i+2] & i_rc_flag_out[i+2]); // [R01]
		end
		if (wd_sel) begin
			sh_d[NS-1]    = i_watchdog_flag_out; // [R05]
			sh_oe_d[NS-1] = 1'b1; // [R05]
		end
	end

	// Register pad outputs and the watchdog status path.
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_shared_flag_pad    <= '0;
			o_shared_flag_pad_oe <= '0;
			o_audio_flag_pad     <= '0;
			o_audio_flag_pad_oe  <= '0;
			o_wd_status_flag     <= '0;
		end else begin
			o_shared_flag_pad    <= sh_d;
			o_shared_flag_pad_oe <= sh_oe_d;
			o_audio_flag_pad     <= i_aud_flag_out[1:0] & aud_dir_q[1:0]; // [R04]
			o_audio_flag_pad_oe  <= aud_dir_q[1:0]; // [R04]
			o_wd_status_flag     <= {i_rc_flag_out[8] & rc_dir_q[8],
			                         i_aud_flag_out[8] & aud_dir_q[8]}; // [R06]
		end
	end

	// Input side of every user flag, one cell per core and per flag.
	for (genvar g = 0; g < NU; g++) begin : g_user
		flag_cell u_aud (
			.i_mclk    (i_mclk),
			.i_rstn    (i_rstn),
			.i_stretch (aud_str_q[g]), // [R20]
			.i_enable  (~aud_dir_q[g]),
			.i_level   (pad_lvl[g]),
			.i_sampled (i_aud_sampled[g]),
			.o_flag    (o_aud_flag_in[g])
		);
		flag_cell u_rc (
			.i_mclk    (i_mclk),
			.i_rstn    (i_rstn),
			.i_stretch (rc_str_q[g]), // [R20]
			.i_enable  (~rc_dir_q[g]),
			.i_level   (pad_lvl[g]),
			.i_sampled (i_rc_sampled[g]),
			.o_flag    (o_rc_flag_in[g])
		);
	end

	// New-sample flags: stretch fixed on, only enable programmable.
	for (genvar g = 0; g < flag_mbox_pkg::NUM_NEWSAM; g++) begin : g_ns
		flag_cell u_ns (
			.i_mclk    (i_mclk),
			.i_rstn    (i_rstn),
			.i_stretch (1'b1), // [R14]
			.i_enable  (ns_en_q[g]), // [R21]
			.i_level   (ns_s2_q[g]), // [R15]
			.i_sampled (i_newsam_sampled[g]),
			.o_flag    (o_newsam_flag[g])
		);
	end

	// Timestamps, switchbox settings and instruction decode are registered.
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_tstamp   <= '0;
			o_src_sel  <= '0;
			o_src_fmt  <= '0;
			o_ext_bus  <= '0;
			o_latch_en <= '0;
		end else begin
			o_tstamp   <= i_tstamp; // [R16]
			o_src_sel  <= sel_q; // [R17]
			o_src_fmt  <= fmt_q; // [R17]
			o_ext_bus  <= i_instr_rd ? i_mux_src[i_instr_sel*W +: W] : '0; // [R07]
			o_latch_en <= i_instr_wr ? (NUM_LE'(1) << i_instr_le) : '0; // [R07]
		end
	end

	// Forward channel: audio sends, radio receives.
	mbox_channel u_fwd (
		.i_mclk      (i_mclk),
		.i_rstn      (i_rstn),
		.i_snd       (i_aud_mbox), // [R08] [R09]
		.i_rcv_rd2   (i_rad_mbox.rd2),
		.o_word1     (o_fwd_words[W-1:0]),
		.o_word2     (o_fwd_words[2*W-1:W]),
		.o_snd_empty (o_aud_empty),
		.o_rcv_full  (o_rad_full)
	);

	// Reverse channel: radio sends, audio receives.
	mbox_channel u_rev (
		.i_mclk      (i_mclk),
		.i_rstn      (i_rstn),
		.i_snd       (i_rad_mbox), // [R08] [R09]
		.i_rcv_rd2   (i_aud_mbox.rd2),
		.o_word1     (o_rev_words[W-1:0]),
		.o_word2     (o_rev_words[2*W-1:W]),
		.o_snd_empty (o_rad_empty),
		.o_rcv_full  (o_aud_full)
	);

endmodule : dsp_flag_and_mailbox_io

// file: core/flag_mbox_pkg.sv
package flag_mbox_pkg;

	// Register map reached over the configuration port.
	localparam logic [7:0] WDT_CTL_ADDR   = 8'h90;
	localparam logic [7:0] WDT_CTL_RESET  = 8'h00;
	localparam int         WD_SEL_BIT     = 0;
	localparam logic [7:0] AUD_DIR_ADDR   = 8'h91;
	localparam logic [7:0] AUD_STR_ADDR   = 8'h92;
	localparam logic [7:0] RC_DIR_ADDR    = 8'h93;
	localparam logic [7:0] RC_STR_ADDR    = 8'h94;
	localparam logic [7:0] NS_EN_ADDR     = 8'h95;
	localparam logic [7:0] SRC_SEL_ADDR   = 8'h96;
	localparam logic [7:0] FMT_ADDR       = 8'h97;
	localparam logic [7:0] FLAG_IN_ADDR   = 8'h98;

	// Flag geometry.
	localparam int FLAG_LO    = 6;
	localparam int FLAG_HI    = 11;
	localparam int NUM_SHARED = 6;
	localparam int NUM_USER   = 9;
	localparam int NUM_NEWSAM = 6;
	localparam int WORD_W     = 24;
	localparam int NUM_INPUTS = 5;
	localparam int SEL_W      = 3;
	localparam int FMT_W      = 2;

	// Configuration write from either the host port or the audio core.
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} cfg_req_s;

	// One mailbox access port of a core.
	typedef struct packed {
		logic              wr1;
		logic              wr2;
		logic              rd2;
		logic [WORD_W-1:0] wdata;
	} mbox_req_s;

endpackage : flag_mbox_pkg

// file: core/flag_cell.sv
`timescale 1ns/1ps

// One core flag: pin sampling plus optional pulse stretching.
module flag_cell (
	// Clock and reset.
	input  wire logic i_mclk,
	input  wire logic i_rstn,
	// Control.
	input  wire logic i_stretch,
	input  wire logic i_enable,
	input  wire logic i_level,
	input  wire logic i_sampled,
	// Result.
	output logic      o_flag
);

	logic held_q;
	logic held_d;
	logic flag_d;

	// Held pulse stays set until the core samples it; a new pulse wins.
	always_comb begin
		held_d = held_q;
		if (!i_enable) begin
			held_d = 1'b0;
		end else if (i_level) begin
			held_d = 1'b1;
		end else if (i_sampled) begin
			held_d = 1'b0;
		end
		flag_d = i_enable & (i_stretch ? held_d : i_level);
	end

	// Register the held pulse and the visible flag.
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			held_q <= 1'b0;
			o_flag <= 1'b0;
		end else begin
			held_q <= held_d;
			o_flag <= flag_d;
		end
	end

endmodule : flag_cell

// file: core/mbox_channel.sv
`timescale 1ns/1ps

// One mailbox direction: two 24-bit words plus empty/full flags.
module mbox_channel (
	// Clock and reset.
	input  wire logic                              i_mclk,
	input  wire logic                              i_rstn,
	// Sender and receiver strobes.
	input  wire flag_mbox_pkg::mbox_req_s          i_snd,
	input  wire logic                              i_rcv_rd2,
	// Data and handshake flags.
	output logic [flag_mbox_pkg::WORD_W-1:0]       o_word1,
	output logic [flag_mbox_pkg::WORD_W-1:0]       o_word2,
	output logic                                   o_snd_empty,
	output logic                                   o_rcv_full
);

	logic [flag_mbox_pkg::WORD_W-1:0] w1_d;
	logic [flag_mbox_pkg::WORD_W-1:0] w2_d;
	logic                             full_d;

	// Data never depends on the flags, so polling-free use also works.
	always_comb begin
		w1_d   = i_snd.wr1 ? i_snd.wdata : o_word1; // [R10]
		w2_d   = i_snd.wr2 ? i_snd.wdata : o_word2; // [R10]
		full_d = o_rcv_full;
		if (i_snd.wr2) begin
			full_d = 1'b1; // [R11] [R12] [R19]
		end else if (i_rcv_rd2) begin
			full_d = 1'b0; // [R11] [R12] [R19]
		end
	end

	// Flags update one edge after the strobe, hence the one-slot gap.
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_word1     <= '0;
			o_word2     <= '0;
			o_rcv_full  <= 1'b0;
			o_snd_empty <= 1'b1;
		end else begin
			o_word1     <= w1_d;
			o_word2     <= w2_d;
			o_rcv_full  <= full_d; // [R13]
			o_snd_empty <= ~full_d; // [R12]
		end
	end

endmodule : mbox_channel

// file: verif/flag_mbox_monitor.sv
`timescale 1ns/1ps

// Watches the mailbox flags, the shared pads and the instruction bus path.
module flag_mbox_monitor (
	// Clock and reset.
	input wire logic                     i_mclk,
	input wire logic                     i_rstn,
	// Observed ports.
	input wire flag_mbox_pkg::cfg_req_s  i_host_cfg,
	input wire logic                     i_watchdog_flag_out,
	input wire logic [5:0]               o_shared_flag_pad,
	input wire logic [5:0]               o_shared_flag_pad_oe,
	input wire logic                     i_instr_rd,
	input wire logic [23:0]              o_ext_bus,
	input wire flag_mbox_pkg::mbox_req_s i_aud_mbox,
	input wire flag_mbox_pkg::mbox_req_s i_rad_mbox,
	input wire logic [47:0]              o_fwd_words,
	input wire logic                     o_aud_empty,
	input wire logic                     o_rad_full,
	input wire logic                     o_rad_empty,
	input wire logic                     o_aud_full
);
	logic wd_sel_q;
	logic wd_sel_d;

	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_rstn);

	// Shadow of the pad eleven owner; audio core writes are not followed.
	always_comb begin
		wd_sel_d = wd_sel_q;
		if (i_host_cfg.wr &&
		    i_host_cfg.addr == flag_mbox_pkg::WDT_CTL_ADDR) begin
			wd_sel_d = i_host_cfg.wdata[flag_mbox_pkg::WD_SEL_BIT];
		end
	end

	// Registers the shadow bit.
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			wd_sel_q <= 1'b0;
		end else begin
			wd_sel_q <= wd_sel_d;
		end
	end

	// Flag steps of a second word write on each channel.
	sequence s_fwd_loaded;
		o_rad_full && !o_aud_empty
			&& o_fwd_words[47:24] == $past(i_aud_mbox.wdata);
	endsequence
	sequence s_rev_loaded;
		o_aud_full && !o_rad_empty;
	endsequence

	property p_fwd_write;
		i_aud_mbox.wr2 |=> s_fwd_loaded;
	endproperty
	a_fwd_write: assert property (p_fwd_write)
		else $error("forward write did not load and flag");

	property p_fwd_read;
		i_rad_mbox.rd2 && !i_aud_mbox.wr2 |=> !o_rad_full && o_aud_empty;
	endproperty
	a_fwd_read: assert property (p_fwd_read)
		else $error("forward read did not free the channel");

	property p_rev_write;
		i_rad_mbox.wr2 |=> s_rev_loaded;
	endproperty
	a_rev_write: assert property (p_rev_write)
		else $error("reverse write did not flag");

	property p_rev_read;
		i_aud_mbox.rd2 && !i_rad_mbox.wr2 |=> !o_aud_full && o_rad_empty;
	endproperty
	a_rev_read: assert property (p_rev_read)
		else $error("reverse read did not free the channel");

	property p_flag_quiet;
		!i_aud_mbox.wr2 && !i_rad_mbox.rd2
			|=> $stable(o_rad_full) && $stable(o_aud_empty);
	endproperty
	a_flag_quiet: assert property (p_flag_quiet)
		else $error("forward flags moved without a strobe");

	property p_pad_input;
		(o_shared_flag_pad & ~o_shared_flag_pad_oe) == 6'h00;
	endproperty
	a_pad_input: assert property (p_pad_input)
		else $error("undriven shared pad shows a value");

	property p_wd_pad;
		wd_sel_q |=> o_shared_flag_pad_oe[5]
			&& o_shared_flag_pad[5] == $past(i_watchdog_flag_out);
	endproperty
	a_wd_pad: assert property (p_wd_pad)
		else $error("pad eleven does not carry the watchdog flag");

	property p_ext_idle;
		!i_instr_rd |=> o_ext_bus == 24'h000000;
	endproperty
	a_ext_idle: assert property (p_ext_idle)
		else $error("external bus driven without a read");
endmodule : flag_mbox_monitor

bind dsp_flag_and_mailbox_io flag_mbox_monitor u_mon (
	.i_mclk(i_mclk), .i_rstn(i_rstn), .i_host_cfg(i_host_cfg),
	.i_watchdog_flag_out(i_watchdog_flag_out),
	.o_shared_flag_pad(o_shared_flag_pad),
	.o_shared_flag_pad_oe(o_shared_flag_pad_oe),
	.i_instr_rd(i_instr_rd), .o_ext_bus(o_ext_bus),
	.i_aud_mbox(i_aud_mbox), .i_rad_mbox(i_rad_mbox),
	.o_fwd_words(o_fwd_words), .o_aud_empty(o_aud_empty),
	.o_rad_full(o_rad_full), .o_rad_empty(o_rad_empty),
	.o_aud_full(o_aud_full)
);

// file: verif/radio_core_model.sv
`timescale 1ns/1ps

// Radio side mailbox user: drains the forward channel, fills the reverse.
module radio_core_model (
	// Clock and reset.
	input  wire logic                i_mclk,
	input  wire logic                i_rstn,
	// Commands from the bench.
	input  wire logic [3:0]          i_delay,
	input  wire logic                i_send,
	input  wire logic [23:0]         i_send_data,
	// Mailbox side.
	input  wire logic                i_full,
	output flag_mbox_pkg::mbox_req_s o_req
);
	int wait_cnt;

	// Reads a programmable time after full, so slow answers get exercised.
	// Idle data toggles, since a released bus holds no useful value.
	always @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_req    <= '0;
			wait_cnt <= 0;
		end else begin
			o_req.wr2   <= i_send;
			o_req.wdata <= i_send ? i_send_data : ~o_req.wdata;
			if (i_full && !o_req.rd2 && wait_cnt >= i_delay) begin
				o_req.rd2 <= 1'b1;
				wait_cnt  <= 0;
			end else begin
				o_req.rd2 <= 1'b0;
				if (i_full && !o_req.rd2) begin
					wait_cnt <= wait_cnt + 1;
				end
			end
		end
	end
endmodule : radio_core_model

// file: verif/dsp_flag_and_mailbox_io_tb_top.sv
`timescale 1ns/1ps

// Bench: host and audio core are driven here, the radio core by its model.
module dsp_flag_and_mailbox_io_tb_top;
	logic                     i_mclk, i_rstn, wd_out, send, ird, iwr;
	logic                     aud_e, rad_f, rad_e, aud_f;
	flag_mbox_pkg::cfg_req_s  host_cfg, aud_cfg;
	flag_mbox_pkg::mbox_req_s aud_mbox, rad_mbox;
	logic [8:0]               aud_out, rc_out, aud_in, rc_in;
	logic [5:0]               newsam, ns_smp, ns_flag, spad, spad_oe;
	logic [1:0]               wd_stat, apad, apad_oe;
	logic [23:0]              sdata, ext_bus;
	logic [7:0]               cfg_rdata, le;
	logic [143:0]             ts, ts_o;
	logic [191:0]             mux;
	logic [14:0]              sel;
	logic [9:0]               fmt;
	logic [47:0]              fwd, rev;
	logic [2:0]               isel, ile;
	int                       bad_count, check_count;

	// Design under test; only the pad inputs and the user flag acknowledges are tied.
	dsp_flag_and_mailbox_io uut (
		.i_mclk(i_mclk), .i_rstn(i_rstn), .i_host_cfg(host_cfg),
		.i_aud_cfg(aud_cfg), .o_cfg_rdata(cfg_rdata),
		.i_aud_flag_out(aud_out), .i_rc_flag_out(rc_out),
		.i_aud_sampled(9'h000), .i_rc_sampled(9'h000),
		.o_aud_flag_in(aud_in), .o_rc_flag_in(rc_in),
		.i_watchdog_flag_out(wd_out), .o_wd_status_flag(wd_stat),
		.i_shared_flag_pad(6'h00), .o_shared_flag_pad(spad),
		.o_shared_flag_pad_oe(spad_oe), .i_audio_flag_pad(2'h0),
		.o_audio_flag_pad(apad), .o_audio_flag_pad_oe(apad_oe),
		.i_newsam(newsam), .i_newsam_sampled(ns_smp),
		.o_newsam_flag(ns_flag), .i_tstamp(ts), .o_tstamp(ts_o),
		.o_src_sel(sel), .o_src_fmt(fmt), .i_instr_sel(isel),
		.i_instr_rd(ird), .i_instr_le(ile), .i_instr_wr(iwr),
		.i_mux_src(mux), .o_ext_bus(ext_bus), .o_latch_en(le),
		.i_aud_mbox(aud_mbox), .i_rad_mbox(rad_mbox),
		.o_fwd_words(fwd), .o_rev_words(rev), .o_aud_empty(aud_e),
		.o_rad_full(rad_f), .o_rad_empty(rad_e), .o_aud_full(aud_f)
	);

	// The radio core answers slowly so the full flag can be observed.
	radio_core_model u_radio (
		.i_mclk(i_mclk), .i_rstn(i_rstn), .i_delay(4'h6), .i_send(send),
		.i_send_data(sdata), .i_full(rad_f), .o_req(rad_mbox)
	);

	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic close_out();
		$display("mismatches=%0d checks=%0d", bad_count, check_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : close_out

	task automatic settle();
		repeat (3) @(posedge i_mclk);
		#1;
	endtask : settle

	task automatic cfg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_mclk);
		host_cfg <= {1'b1, 1'b0, a, d};
		@(posedge i_mclk);
		host_cfg <= '0;
	endtask : cfg_wr

	task automatic cfg_rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge i_mclk);
		host_cfg <= {1'b0, 1'b1, a, 8'h00};
		@(posedge i_mclk);
		host_cfg <= '0;
		#1 chk(cfg_rdata, e);
	endtask : cfg_rd

	task automatic aud_op(input logic [2:0] s, input logic [23:0] d);
		@(posedge i_mclk);
		aud_mbox <= {s, d};
		@(posedge i_mclk);
		aud_mbox <= {3'b000, ~d};
	endtask : aud_op

	task automatic t_reset();
		chk({aud_e, rad_e, rad_f, aud_f}, 4'b1100);
		cfg_rd(flag_mbox_pkg::WDT_CTL_ADDR, flag_mbox_pkg::WDT_CTL_RESET);
		cfg_rd(8'h7f, 8'h00);
	endtask : t_reset

	task automatic t_fwd();
		aud_op(3'b100, 24'h0a0b0c);
		aud_op(3'b010, 24'h123456);
		#1 chk({rad_f, aud_e}, 2'b10);
		chk(fwd, 48'h123456_0a0b0c);
		for (int i = 0; i < 20 && rad_f; i++) @(posedge i_mclk);
		#1 chk({rad_f, aud_e}, 2'b01);
		chk(fwd, 48'h123456_0a0b0c);
	endtask : t_fwd

	task automatic t_rev();
		@(posedge i_mclk);
		send  <= 1'b1;
		sdata <= 24'h654321;
		@(posedge i_mclk);
		send <= 1'b0;
		for (int i = 0; i < 20 && !aud_f; i++) @(posedge i_mclk);
		#1 chk({rev[47:24], aud_f, rad_e}, {24'h654321, 2'b10});
		aud_op(3'b001, 24'h000000);
		#1 chk({aud_f, rad_e}, 2'b01);
	endtask : t_rev

	task automatic t_pads();
		cfg_wr(flag_mbox_pkg::AUD_DIR_ADDR, 8'h05);
		aud_out <= 9'h005;
		settle();
		chk({spad_oe, spad}, 12'h041);
		chk({apad_oe[0], apad[0]}, 2'b11);
		cfg_wr(flag_mbox_pkg::RC_DIR_ADDR, 8'h04);
		aud_out <= 9'h001;
		rc_out  <= 9'h004;
		settle();
		chk({spad_oe, spad}, 12'h041);
		cfg_wr(flag_mbox_pkg::AUD_DIR_ADDR, 8'h00);
		cfg_wr(flag_mbox_pkg::RC_DIR_ADDR, 8'h00);
		settle();
		chk(spad_oe, 6'h00);
		wd_out <= 1'b1;
		cfg_wr(flag_mbox_pkg::WDT_CTL_ADDR, 8'h01);
		settle();
		chk({spad_oe[5], spad[5]}, 2'b11);
		cfg_rd(flag_mbox_pkg::WDT_CTL_ADDR, 8'h01);
	endtask : t_pads

	task automatic t_newsam();
		for (int k = -1; k < 6; k++) begin
			@(posedge i_mclk);
			newsam <= (k < 0) ? 6'h01 : 6'h01 << k;
			repeat (2) @(posedge i_mclk);
			newsam <= 6'h00;
			settle();
			chk(ns_flag, (k < 0) ? 6'h00 : 6'h01 << k);
			if (k < 0) cfg_wr(flag_mbox_pkg::NS_EN_ADDR, 8'h3f);
			@(posedge i_mclk);
			ns_smp <= (k < 0) ? 6'h00 : 6'h01 << k;
			@(posedge i_mclk);
			ns_smp <= 6'h00;
			settle();
			chk(ns_flag, 6'h00);
		end
	endtask : t_newsam

	task automatic t_bus();
		cfg_wr(flag_mbox_pkg::SRC_SEL_ADDR, 8'h12);
		cfg_wr(flag_mbox_pkg::SRC_SEL_ADDR, 8'h34);
		@(posedge i_mclk);
		aud_cfg <= {1'b1, 1'b0, flag_mbox_pkg::FMT_ADDR, 8'hab};
		isel    <= 3'd2;
		ird     <= 1'b1;
		ile     <= 3'd3;
		iwr     <= 1'b1;
		@(posedge i_mclk);
		aud_cfg <= '0;
		ird     <= 1'b0;
		iwr     <= 1'b0;
		#1 chk({ext_bus, le}, {24'hc3a5e1, 8'h08});
		// The switchbox outputs copy the settings one edge after the write.
		@(posedge i_mclk);
		#1 chk({sel, fmt}, {15'h1234, 10'h0ab});
		chk(ts_o[23:0], ts[23:0]);
		cfg_wr(flag_mbox_pkg::NS_EN_ADDR, 8'h7f);
		aud_out <= 9'h100;
		settle();
		chk({wd_stat, aud_in[8], rc_in[8]}, 4'b0101);
	endtask : t_bus

	initial begin
		i_mclk = 1'b0;
		forever #2 i_mclk = ~i_mclk;
	end

	// Watchdog sized well above the roughly 145 cycles the tests need.
	initial begin
		#40000;
		bad_count++;
		close_out();
	end

	// Main sequence: quiet inputs, reset for six cycles, then the scenarios.
	initial begin
		{host_cfg, aud_cfg, aud_mbox, aud_out, rc_out} = '0;
		{newsam, ns_smp, wd_out, send, sdata, isel, ile, ird, iwr} = '0;
		ts  = {6{24'h5a0f3c}};
		mux = '0;
		mux[71:48] = 24'hc3a5e1;
		i_rstn = 1'b0;
		repeat (6) @(posedge i_mclk);
		i_rstn <= 1'b1;
		@(posedge i_mclk);
		#1;
		t_reset();
		t_fwd();
		t_rev();
		t_pads();
		t_newsam();
		t_bus();
		close_out();
	end
endmodule : dsp_flag_and_mailbox_io_tb_top
